// ==== hw/agc_core.sv ====
// Automatic gain control for the mono record channel, with its config registers.
// Assumes sample_valid and level come from ADC logic on the same clock, one
// strobe per ADC sample, and that registers are written over the byte port.
`timescale 1ns/1ns

// Operation
// - The loop adjusts gain only while the enable bit is set, else it is bypassed at 0 dB.
// - A three-bit target code picks -5.5, -8, -10, -12, -14, -17, -20 or -24 dB.
// - A two-bit hysteresis code picks 1, 2 or 4 dB, and code 11 turns it off.
// - A zero noise-threshold code turns noise and silence detection off.
// - Nonzero noise codes give thresholds from -30 dB down to -90 dB in 2 dB steps.
// - The seven-bit ceiling caps the applied gain at 0 to 59.5 dB in half-dB steps.
// - The attack code n sets a base time of 2n+1 units of 32 samples.
// - The attack multiplier m scales the attack time by two to the power m.
// - The decay code n sets a base time of 2n+1 units of 512 samples.
// - The decay multiplier m scales the decay time by two to the power m.
// - All attack and decay timing counts ADC sample periods, not clock cycles.
module agc_core
	import agc_pkg::*;
#(
	parameter int unsigned LEVEL_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [LEVEL_W-1:0] level,
	output logic signed [7:0] gain,
	output logic active,
	output logic silence
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic en;
		logic [2:0] tgt;
		logic [1:0] hyst;
		logic [4:0] noise;
		logic [6:0] ceil;
		logic [7:0] atk;
		logic [7:0] dcy;
		logic [7:0] rsv_a;
		logic [7:0] rsv_b;
		logic [7:0] rdata;
		logic signed [7:0] gain;
		logic silence;
		agc_phase_type phase;
		logic [AGC_CNT_W-1:0] cnt;
	} agc_state_type;

	agc_state_type q;
	agc_state_type d;

	// ****************************************
	// Decoders
	// ****************************************

	// Target as attenuation below full scale, half-dB units
	function automatic logic signed [9:0] agc_target(input logic [2:0] code);
		logic signed [9:0] t;
		t = 10'sd0;
		unique case (code)
			3'h0: t = 10'sd11;
			3'h1: t = 10'sd16;
			3'h2: t = 10'sd20;
			3'h3: t = 10'sd24;
			3'h4: t = 10'sd28;
			3'h5: t = 10'sd34;
			3'h6: t = 10'sd40;
			3'h7: t = 10'sd48;
		endcase
		return t;
	endfunction : agc_target

	// Hysteresis band in half-dB units
	function automatic logic signed [9:0] agc_hyst(input logic [1:0] code);
		logic signed [9:0] h;
		h = 10'sd0;
		unique case (code)
			2'h0: h = 10'sd2;
			2'h1: h = 10'sd4;
			2'h2: h = 10'sd8;
			2'h3: h = 10'sd0;
		endcase
		return h;
	endfunction : agc_hyst

	// Step period in samples: (2n+1) units, unit a power of two, times 2^m
	function automatic logic [AGC_CNT_W-1:0] agc_period(
		input logic [7:0] code,
		input int unsigned unit_shift
	);
		logic [AGC_CNT_W-1:0] p;
		p = {{(AGC_CNT_W-6){1'b0}}, code[7:AGC_TIME_LSB], 1'b1};
		p = p << unit_shift;
		p = p << code[AGC_TIME_LSB-1:0];
		return p;
	endfunction : agc_period

	// ****************************************
	// Loop arithmetic
	// ****************************************
	logic signed [9:0] out_att;
	logic signed [9:0] tgt_att;
	logic [9:0] noise_att;
	logic [6:0] ceil_eff;
	logic signed [7:0] ceil_gain;
	logic loud;
	logic quiet;
	logic below_noise;
	logic [AGC_CNT_W-1:0] atk_period;
	logic [AGC_CNT_W-1:0] dcy_period;
	logic [AGC_CNT_W-1:0] cur_period;
	agc_phase_type want;

	// Output level is input attenuation less applied gain; smaller means louder
	assign out_att = $signed({{(10-LEVEL_W){1'b0}}, level}) - $signed({{2{q.gain[7]}}, q.gain});
	assign tgt_att = agc_target(q.tgt);
	assign noise_att = AGC_NOISE_BASE + 10'({q.noise, {AGC_NOISE_STEP_SHIFT{1'b0}}});
	// A reserved ceiling code is held at the top legal value rather than trusted
	assign ceil_eff = (q.ceil > AGC_CEIL_TOP) ? AGC_CEIL_TOP : q.ceil;
	assign ceil_gain = $signed({1'b0, ceil_eff});
	assign loud = out_att < (tgt_att - agc_hyst(q.hyst));
	assign quiet = out_att > tgt_att;
	assign below_noise = (q.noise != 5'h00) && ({{(10-LEVEL_W){1'b0}}, level} > noise_att);
	assign atk_period = agc_period(q.atk, AGC_ATK_UNIT_SHIFT);
	assign dcy_period = agc_period(q.dcy, AGC_DCY_UNIT_SHIFT);
	assign cur_period = (q.phase == AGC_ATTACK) ? atk_period : dcy_period;

	// Direction the loop wants to move this sample
	always_comb begin
		want = AGC_HOLD;
		if (loud) begin
			want = AGC_ATTACK;
		end else if (quiet && !below_noise && (q.gain < ceil_gain)) begin
			want = AGC_DECAY;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	// Register port, then one loop step per ADC sample strobe
	always_comb begin
		d = q;
		if (reg_wr) begin
			// Reserved bits are dropped; they read back as zero
			unique case (reg_addr)
				AGC_OFS_RSV_A: d.rsv_a = reg_wdata;
				AGC_OFS_RSV_B: d.rsv_b = reg_wdata;
				AGC_OFS_EN_TGT: begin
					d.en = reg_wdata[AGC_EN_BIT];
					d.tgt = reg_wdata[AGC_TGT_LSB+:3];
				end
				AGC_OFS_HYST_NOISE: begin
					d.hyst = reg_wdata[AGC_HYST_LSB+:2];
					d.noise = reg_wdata[AGC_NOISE_LSB+:5];
				end
				AGC_OFS_CEIL: d.ceil = reg_wdata[6:0];
				AGC_OFS_ATTACK: d.atk = reg_wdata;
				AGC_OFS_DECAY: d.dcy = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				AGC_OFS_RSV_A: d.rdata = q.rsv_a;
				AGC_OFS_RSV_B: d.rdata = q.rsv_b;
				AGC_OFS_EN_TGT: d.rdata = {q.en, q.tgt, 4'h0};
				AGC_OFS_HYST_NOISE: d.rdata = {q.hyst, q.noise, 1'b0};
				AGC_OFS_CEIL: d.rdata = {1'b0, q.ceil};
				AGC_OFS_ATTACK: d.rdata = q.atk;
				AGC_OFS_DECAY: d.rdata = q.dcy;
				default: d.rdata = 8'h00;
			endcase
		end
		// Timers advance only on sample strobes, so they track the record rate
		if (sample_valid) begin
			if (!q.en) begin
				// Bypass: unity gain and a clean restart when enabled again
				d.gain = AGC_GAIN_ZERO;
				d.phase = AGC_HOLD;
				d.cnt = '0;
				d.silence = 1'b0;
			end else begin
				d.silence = below_noise;
				if (q.gain > ceil_gain) begin
					// Ceiling lowered under us: walk down one step per sample
					d.gain = q.gain - 8'sd1;
					d.phase = AGC_HOLD;
					d.cnt = '0;
				end else if (want != q.phase) begin
					// Direction change restarts the time constant
					d.phase = want;
					d.cnt = '0;
				end else if (q.phase != AGC_HOLD) begin
					if (q.cnt + 1'b1 >= cur_period) begin
						d.cnt = '0;
						if (q.phase == AGC_ATTACK) begin
							if (q.gain > AGC_GAIN_MIN) begin
								d.gain = q.gain - 8'sd1;
							end
						end else begin
							d.gain = q.gain + 8'sd1;
						end
					end else begin
						d.cnt = q.cnt + 1'b1;
					end
				end
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{
				en: 1'b0,
				tgt: 3'h0,
				hyst: 2'h0,
				noise: 5'h00,
				ceil: AGC_CEIL_RST,
				atk: 8'h00,
				dcy: 8'h00,
				rsv_a: AGC_RSV_RST,
				rsv_b: AGC_RSV_RST,
				rdata: 8'h00,
				gain: AGC_GAIN_ZERO,
				silence: 1'b0,
				phase: AGC_HOLD,
				cnt: '0
			};
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs, all straight from flops
	// ****************************************
	assign reg_rdata = q.rdata;
	assign gain = q.gain;
	assign active = q.en;
	assign silence = q.silence;

endmodule : agc_core

// ==== pkg/agc_pkg.sv ====
// Constants for the record-channel automatic gain control block.
// Assumes a byte-wide register port and a sample strobe at the ADC rate.
package agc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [6:0] AGC_OFS_RSV_A = 7'h54;
	localparam logic [6:0] AGC_OFS_RSV_B = 7'h55;
	localparam logic [6:0] AGC_OFS_EN_TGT = 7'h56;
	localparam logic [6:0] AGC_OFS_HYST_NOISE = 7'h57;
	localparam logic [6:0] AGC_OFS_CEIL = 7'h58;
	localparam logic [6:0] AGC_OFS_ATTACK = 7'h59;
	localparam logic [6:0] AGC_OFS_DECAY = 7'h5a;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int unsigned AGC_EN_BIT = 7;
	localparam int unsigned AGC_TGT_LSB = 4;
	localparam int unsigned AGC_HYST_LSB = 6;
	localparam int unsigned AGC_NOISE_LSB = 1;
	localparam int unsigned AGC_TIME_LSB = 3;
	localparam logic [6:0] AGC_CEIL_RST = 7'h7f;
	// Reserved slots power up undefined; a plain value stands in
	localparam logic [7:0] AGC_RSV_RST = 8'h00;

	// ****************************************
	// Levels in half-dB units
	// ****************************************
	localparam logic [6:0] AGC_CEIL_TOP = 7'h77;
	localparam logic signed [7:0] AGC_GAIN_MIN = 8'she8;
	localparam logic signed [7:0] AGC_GAIN_ZERO = 8'sh00;
	localparam logic [9:0] AGC_NOISE_BASE = 10'h038;
	localparam int unsigned AGC_NOISE_STEP_SHIFT = 2;

	// ****************************************
	// Timing units, as powers of two of sample periods
	// ****************************************
	localparam int unsigned AGC_ATK_UNIT_SHIFT = 5;
	localparam int unsigned AGC_DCY_UNIT_SHIFT = 9;
	localparam int unsigned AGC_CNT_W = 22;

	typedef enum logic [1:0] {
		AGC_HOLD,
		AGC_ATTACK,
		AGC_DECAY
	} agc_phase_type;

endpackage : agc_pkg

// ==== sim/agc_monitor.sv ====
// Port-level assertions for the record-channel gain control block.
// Assumes one clock domain; bound to every agc_core instance.
`timescale 1ns/1ns
module agc_monitor
	import agc_pkg::*;
#(
	parameter int unsigned LEVEL_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [LEVEL_W-1:0] level,
	input wire logic signed [7:0] gain,
	input wire logic active,
	input wire logic silence
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Read strobe at one offset
	sequence rd_at(logic [6:0] a);
		reg_rd && reg_addr == a;
	endsequence
	// A sample that may step the gain; samples with a write in the same cycle are left out
	sequence live_smp;
		sample_valid && active && !reg_wr;
	endsequence
	en_track_a: assert property (reg_wr && reg_addr == AGC_OFS_EN_TGT |=> active == $past(reg_wdata[7]))
		else $error("active does not follow enable bit");
	bypass_a: assert property (sample_valid && !active |=> gain == AGC_GAIN_ZERO && !silence)
		else $error("gain moved while disabled");
	ceil_rsvd_a: assert property (rd_at(AGC_OFS_CEIL) |=> !reg_rdata[7])
		else $error("ceiling reserved bit read high");
	ctl_rsvd_a: assert property (rd_at(AGC_OFS_EN_TGT) |=> reg_rdata[3:0] == 4'h0)
		else $error("control reserved nibble read high");
	gain_hold_a: assert property (!sample_valid |=> $stable(gain))
		else $error("gain changed without a sample");
	gain_slew_a: assert property (live_smp |=> gain == $past(gain) || gain == $past(gain) + 8'sh01
		|| gain == $past(gain) - 8'sh01)
		else $error("gain stepped by more than one");
	gain_range_a: assert property (gain >= AGC_GAIN_MIN && gain <= $signed({1'b0, AGC_CEIL_TOP}))
		else $error("gain out of range");
	sil_hold_a: assert property (!sample_valid |=> $stable(silence))
		else $error("silence changed without a sample");
endmodule : agc_monitor

bind agc_core agc_monitor #(.LEVEL_W(LEVEL_W)) u_mon (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.sample_valid(sample_valid), .level(level), .gain(gain), .active(active), .silence(silence));

// ==== sim/auto_gain_control_config_tb_top.sv ====
// Self-checking bench for the gain control block: register access and loop timing.
// Assumes samples may be strobed every cycle, so timers run at the clock rate.
`timescale 1ns/1ns
module auto_gain_control_config_tb_top
	import agc_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic sample_valid = 1'b0;
	logic [7:0] level = 8'h00;
	logic signed [7:0] gain;
	logic active;
	logic silence;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00};
	// Legal values only: reset values in the reserved slots, zero reserved bits, no reserved ceiling code
	logic [7:0] wv_tab [7] = '{8'h00, 8'h00, 8'hf0, 8'hfe, 8'h77, 8'hff, 8'hff};

	agc_core #(.LEVEL_W(8)) dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.level(level), .gain(gain), .active(active), .silence(silence));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : chk8
	// Each access first lets an edge pass, so back-to-back calls never re-drive a strobe in one time step
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#10;
		reg_wr = 1'b0;
	endtask : wr
	// Read data is loaded at the strobe's edge, so compare just after it
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#10;
		reg_rd = 1'b0;
		chk8("reg_rdata", exp, reg_rdata);
	endtask : rd
	// The idle edge before a burst carries no sample, so loop timers do not move
	task automatic smp(input int n);
		@(posedge clk);
		#10;
		sample_valid = 1'b1;
		repeat (n) @(posedge clk);
		#10;
		sample_valid = 1'b0;
	endtask : smp
	task automatic stop_test();
		if (bad_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	// ****************************************
	// Clock and hang guard
	// ****************************************
	initial begin
		forever #50 clk = ~clk;
	end
	// A hung wait would otherwise never reach the verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		#10 arst_n = 1'b1;
		for (int i = 0; i < 7; i++) rd(7'h54 + i[6:0], rst_tab[i]);
		for (int i = 0; i < 7; i++) wr(7'h54 + i[6:0], wv_tab[i]);
		for (int i = 0; i < 7; i++) rd(7'h54 + i[6:0], wv_tab[i]);
		wr(7'h5b, 8'hff);
		rd(7'h5b, 8'h00);
		// Hysteresis off, attack 3x32x2, decay 1x512x2, top legal ceiling, loop off
		wr(AGC_OFS_HYST_NOISE, 8'hc0);
		wr(AGC_OFS_ATTACK, 8'h09);
		wr(AGC_OFS_DECAY, 8'h01);
		wr(AGC_OFS_CEIL, 8'h77);
		wr(AGC_OFS_EN_TGT, 8'h00);
		smp(300);
		chk8("gain", 8'h00, gain);
		chk8("active", 8'h00, {7'h0, active});
		// Loud input: first step one sample after the 192-sample period
		wr(AGC_OFS_EN_TGT, 8'h80);
		chk8("active", 8'h01, {7'h0, active});
		smp(192);
		chk8("gain", 8'h00, gain);
		smp(1);
		chk8("gain", 8'hff, gain);
		smp(192);
		chk8("gain", 8'hfe, gain);
		// Quiet input, noise detection off: rise every 1024 samples
		level = 8'h64;
		smp(1024);
		chk8("gain", 8'hfe, gain);
		smp(1);
		chk8("gain", 8'hff, gain);
		smp(3072);
		chk8("gain", 8'h02, gain);
		chk8("silence", 8'h00, {7'h0, silence});
		// Lowered ceiling pulls the gain down one step per sample, then holds
		wr(AGC_OFS_CEIL, 8'h00);
		smp(1);
		chk8("gain", 8'h01, gain);
		smp(600);
		chk8("gain", 8'h00, gain);
		// Threshold code 1 is 60 half-dB of attenuation
		wr(AGC_OFS_HYST_NOISE, 8'hc2);
		smp(1);
		chk8("silence", 8'h01, {7'h0, silence});
		level = 8'h32;
		smp(1);
		chk8("silence", 8'h00, {7'h0, silence});
		// Target code 7 is 48 half-dB; a 1 dB band holds at 46 and attacks at 45
		wr(AGC_OFS_CEIL, 8'h77);
		wr(AGC_OFS_HYST_NOISE, 8'h00);
		wr(AGC_OFS_EN_TGT, 8'hf0);
		level = 8'h2e;
		smp(1100);
		chk8("gain", 8'h00, gain);
		level = 8'h2d;
		smp(193);
		chk8("gain", 8'hff, gain);
		stop_test();
	end
endmodule : auto_gain_control_config_tb_top
